// ---- pkg/spi_cfg_pkg.sv ----
// Purpose: shared constants and types of the serial configuration port
// Assumes: 13-bit register address, 8-bit registers
// Notes:   reset values are shared by link-side registers and core-side shadow

package spi_cfg_pkg;

    // ----------------------------------------------------------------
    // address space and register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W          = 13;
    localparam int         DATA_W          = 8;
    localparam int         REG_DEPTH       = 256;
    localparam logic [12:0] CFG_ADDR       = 13'h0000;
    localparam logic [12:0] BURST_END_ADDR = 13'h0002;

    // ----------------------------------------------------------------
    // serial_port_config fields and reset values
    // ----------------------------------------------------------------
    localparam int         CFG_OE_BIT      = 7;
    localparam int         CFG_LSB_BIT     = 6;
    localparam int         CFG_SRST_BIT    = 5;
    localparam int         CFG_RSVD_BIT    = 4;
    localparam logic [7:0] CFG_RESET       = 8'h18;
    localparam logic [7:0] BURST_END_RESET = 8'h00;
    localparam logic [7:0] REG_RESET       = 8'h00;

    // ----------------------------------------------------------------
    // header layout and bit counts
    // ----------------------------------------------------------------
    localparam int         HDR_RW_BIT      = 15;
    localparam int         HDR_CNT_HI      = 14;
    localparam int         HDR_CNT_LO      = 13;
    localparam logic [1:0] CNT_FOUR_PLUS   = 2'h3;
    localparam logic [3:0] HDR_LAST_BIT    = 4'hf;
    localparam logic [3:0] HDR_MID_BIT     = 4'h8;
    localparam logic [3:0] BYTE_LAST_BIT   = 4'h7;

    // ----------------------------------------------------------------
    // calibration time after a soft reset
    // ----------------------------------------------------------------
    localparam int         CLOCK_MHZ       = 100;
    localparam int         CAL_TIME_US     = 10;
    localparam int         CAL_CYCLES_DEF  = CAL_TIME_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        ST_HEADER = 2'b00,
        ST_DATA   = 2'b01,
        ST_DONE   = 2'b11
    } link_state_t;

    function automatic logic [7:0] reg_reset_val(input int idx);
        if (idx == int'(CFG_ADDR))
            return CFG_RESET;
        if (idx == int'(BURST_END_ADDR))
            return BURST_END_RESET;
        return REG_RESET;
    endfunction

endpackage

// ---- src/cfg_core_side.sv ----
// Purpose: core-clock copy of the register space and soft reset calibration
// Assumes: write and soft reset events arrive as toggles from the link domain
// Notes:   address and data of a write are held stable by the sender

`timescale 1ns/1ps
`default_nettype none

module cfg_core_side
    import spi_cfg_pkg::*;
#(
    parameter int DEPTH      = REG_DEPTH,
    parameter int CAL_CYCLES = CAL_CYCLES_DEF
)
(
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic              i_wr_tgl,
    input  wire logic [ADDR_W-1:0] i_wr_addr,
    input  wire logic [7:0]        i_wr_data,
    input  wire logic              i_sr_tgl,
    output logic                   o_done_tgl,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [7:0]             o_rd_data,
    output logic                   o_cal_busy
);

    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);

    logic [2:0]    wr_s_q, wr_s_d;
    logic [2:0]    sr_s_q, sr_s_d;
    logic [7:0]    sh_q [DEPTH];
    logic [7:0]    sh_d [DEPTH];
    logic [CW-1:0] cnt_q, cnt_d;
    logic          busy_q, busy_d;
    logic          done_q, done_d;
    logic [7:0]    rd_q, rd_d;
    logic          wr_edge;
    logic          sr_edge;

    // stage 0 of each synchroniser feeds only stage 1
    assign wr_edge = wr_s_q[2] ^ wr_s_q[1];
    assign sr_edge = sr_s_q[2] ^ sr_s_q[1];

    // ----------------------------------------------------------------
    // shadow update and calibration timer
    // ----------------------------------------------------------------
    always_comb
    begin
        wr_s_d = {wr_s_q[1:0], i_wr_tgl};
        sr_s_d = {sr_s_q[1:0], i_sr_tgl};
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = done_q;
        if (wr_edge && (i_wr_addr < DEPTH))
            sh_d[i_wr_addr[IW-1:0]] = i_wr_data;
        if (busy_q)
        begin
            if (cnt_q == CAL_LAST)
            begin
                busy_d = 1'b0;
                done_d = ~done_q;
            end
            else
                cnt_d = cnt_q + CW'(1);
        end
        // a new soft reset restarts calibration; at its last cycle busy stays set but done still toggles
        if (sr_edge)
        begin
            for (int i = 0; i < DEPTH; i++)
                sh_d[i] = reg_reset_val(i);
            busy_d = 1'b1;
            cnt_d  = '0;
        end
        rd_d = (i_rd_addr < DEPTH) ? sh_q[i_rd_addr[IW-1:0]] : 8'h00;
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_s_q <= 3'h0;
            sr_s_q <= 3'h0;
            for (int i = 0; i < DEPTH; i++)
                sh_q[i] <= reg_reset_val(i);
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rd_q   <= 8'h00;
        end
        else
        begin
            wr_s_q <= wr_s_d;
            sr_s_q <= sr_s_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            rd_q   <= rd_d;
        end
    end

    assign o_done_tgl = done_q;
    assign o_rd_data  = rd_q;
    assign o_cal_busy = busy_q;

endmodule

`default_nettype wire

// ---- src/adc_serial_config_port.sv ----
// Purpose: slave end of the serial configuration port, link logic on i_sclk
// Assumes: master keeps the serial clock low while select is high
// Notes:   registers live on the serial clock; the core sees a shadow copy

`timescale 1ns/1ps
`default_nettype none

module adc_serial_config_port
    import spi_cfg_pkg::*;
#(
    parameter int DEPTH      = REG_DEPTH,
    parameter int CAL_CYCLES = CAL_CYCLES_DEF
)
(
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic              i_sclk,
    input  wire logic              i_port_select_n,
    input  wire logic              i_sdio,
    output logic                   o_sdio,
    output logic                   o_sdio_oe_n,
    output logic                   o_dedicated_out_line,
    output logic                   o_dedicated_out_oe_n,
    input  wire logic [ADDR_W-1:0] i_cfg_addr,
    output logic [7:0]             o_cfg_data,
    output logic                   o_cal_busy
);

    localparam int IW = $clog2(DEPTH);

    link_state_t       state_q, state_d, s_eff;
    logic [3:0]        cnt_q, cnt_d, c_eff;
    logic [15:0]       hdr_q, hdr_d, hdr_next;
    logic [7:0]        byte_q, byte_d, byte_next;
    logic [ADDR_W-1:0] addr_q, addr_d, addr_step, rd_sel;
    logic              is_read_q, is_read_d;
    logic [1:0]        code_q, code_d;
    logic [1:0]        bytes_q, bytes_d;
    logic [7:0]        rdb_q, rdb_d, rd_view, cfg_view, burst_end;
    logic [7:0]        mem_q [DEPTH];
    logic [7:0]        mem_d [DEPTH];
    logic              gap_tgl_q, gap_tgl_d, gap_seen_q, gap_seen_d;
    logic              sr_busy_q, sr_busy_d, sr_tgl_q, sr_tgl_d;
    logic              dn1_q, dn2_q, dn_seen_q, dn_seen_d, done_tgl;
    logic              wr_tgl_q, wr_tgl_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [7:0]        wr_data_q, wr_data_d;
    logic              out_q, out_d, drv_q, drv_d;
    logic              lsb, oe_en, stall, stall_ok, restart, finish;
    logic              hdr_done, step_ev;
    logic              core_done_tgl;

    // ----------------------------------------------------------------
    // select pause detector
    // ----------------------------------------------------------------
    // toggles on every rise of select; the serial clock is static then,
    // so the link side may compare it on its next rising edge
    assign gap_tgl_d = ~gap_tgl_q;

    always_ff @(posedge i_port_select_n or posedge i_reset)
    begin
        if (i_reset)
            gap_tgl_q <= 1'b0;
        else
            gap_tgl_q <= gap_tgl_d;
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    assign lsb       = mem_q[0][CFG_LSB_BIT];
    assign oe_en     = mem_q[0][CFG_OE_BIT];
    assign burst_end = mem_q[BURST_END_ADDR[IW-1:0]];
    assign cfg_view  = {oe_en, lsb, sr_busy_q, 1'b1, 1'b1, sr_busy_q, lsb, oe_en};
    assign done_tgl  = dn2_q != dn_seen_q;
    assign stall     = gap_tgl_q != gap_seen_q;

    assign stall_ok = ((state_q == ST_HEADER) &&
                       ((cnt_q == 4'h0) || (cnt_q == HDR_MID_BIT))) ||
                      ((state_q == ST_DATA) && (cnt_q == 4'h0) &&
                       ((code_q != CNT_FOUR_PLUS) || (bytes_q == 2'h0)));

    assign restart = !i_port_select_n && stall && !stall_ok;
    assign s_eff   = restart ? ST_HEADER : state_q;
    assign c_eff   = restart ? 4'h0 : cnt_q;

    assign hdr_next  = lsb ? {i_sdio, hdr_q[15:1]} : {hdr_q[14:0], i_sdio};
    assign byte_next = lsb ? {i_sdio, byte_q[7:1]} : {byte_q[6:0], i_sdio};
    assign addr_step = lsb ? addr_q - 13'h0001 : addr_q + 13'h0001;
    assign rd_sel    = (s_eff == ST_HEADER) ? hdr_next[ADDR_W-1:0] : addr_step;
    assign rd_view   = (rd_sel == CFG_ADDR) ? cfg_view :
                       (rd_sel < DEPTH) ? mem_q[rd_sel[IW-1:0]] : 8'h00;

    assign finish = (code_q == CNT_FOUR_PLUS) ?
                    (addr_q == {5'h00, burst_end}) :
                    (bytes_q == code_q);

    assign hdr_done = !i_port_select_n && (s_eff == ST_HEADER) && (c_eff == HDR_LAST_BIT);
    assign step_ev  = !i_port_select_n && (s_eff == ST_DATA) && (c_eff == BYTE_LAST_BIT);

    // ----------------------------------------------------------------
    // link state machine and register array
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        hdr_d      = hdr_q;
        byte_d     = byte_q;
        addr_d     = addr_q;
        is_read_d  = is_read_q;
        code_d     = code_q;
        bytes_d    = bytes_q;
        rdb_d      = rdb_q;
        mem_d      = mem_q;
        gap_seen_d = gap_seen_q;
        sr_tgl_d   = sr_tgl_q;
        wr_tgl_d   = wr_tgl_q;
        wr_addr_d  = wr_addr_q;
        wr_data_d  = wr_data_q;
        dn_seen_d  = dn2_q;
        sr_busy_d  = sr_busy_q;
        if (done_tgl)
            sr_busy_d = 1'b0;
        if (!i_port_select_n)
        begin
            gap_seen_d = gap_tgl_q;
            case (s_eff)
                ST_HEADER:
                begin
                    hdr_d = hdr_next;
                    if (c_eff == HDR_LAST_BIT)
                    begin
                        is_read_d = hdr_next[HDR_RW_BIT];
                        code_d    = hdr_next[HDR_CNT_HI:HDR_CNT_LO];
                        addr_d    = hdr_next[ADDR_W-1:0];
                        bytes_d   = 2'h0;
                        rdb_d     = rd_view;
                        state_d   = ST_DATA;
                        cnt_d     = 4'h0;
                    end
                    else
                    begin
                        state_d = ST_HEADER;
                        cnt_d   = c_eff + 4'h1;
                    end
                end
                ST_DATA:
                begin
                    byte_d = byte_next;
                    if (c_eff == BYTE_LAST_BIT)
                    begin
                        if (!is_read_q)
                        begin
                            wr_tgl_d  = ~wr_tgl_q;
                            wr_addr_d = addr_q;
                            wr_data_d = byte_next;
                            if (addr_q < DEPTH)
                                mem_d[addr_q[IW-1:0]] = byte_next;
                            if ((addr_q == CFG_ADDR) && byte_next[CFG_SRST_BIT])
                            begin
                                for (int i = 0; i < DEPTH; i++)
                                    mem_d[i] = reg_reset_val(i);
                                sr_busy_d = 1'b1;
                                sr_tgl_d  = ~sr_tgl_q;
                            end
                        end
                        addr_d  = addr_step;
                        rdb_d   = rd_view;
                        bytes_d = (bytes_q == 2'h3) ? bytes_q : bytes_q + 2'h1;
                        state_d = finish ? ST_DONE : ST_DATA;
                        cnt_d   = 4'h0;
                    end
                    else
                    begin
                        state_d = ST_DATA;
                        cnt_d   = c_eff + 4'h1;
                    end
                end
                default:
                begin
                    state_d = ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q    <= ST_HEADER;
            cnt_q      <= 4'h0;
            hdr_q      <= 16'h0000;
            byte_q     <= 8'h00;
            addr_q     <= '0;
            is_read_q  <= 1'b0;
            code_q     <= 2'h0;
            bytes_q    <= 2'h0;
            rdb_q      <= 8'h00;
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= reg_reset_val(i);
            gap_seen_q <= 1'b0;
            sr_busy_q  <= 1'b0;
            sr_tgl_q   <= 1'b0;
            dn1_q      <= 1'b0;
            dn2_q      <= 1'b0;
            dn_seen_q  <= 1'b0;
            wr_tgl_q   <= 1'b0;
            wr_addr_q  <= '0;
            wr_data_q  <= 8'h00;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            hdr_q      <= hdr_d;
            byte_q     <= byte_d;
            addr_q     <= addr_d;
            is_read_q  <= is_read_d;
            code_q     <= code_d;
            bytes_q    <= bytes_d;
            rdb_q      <= rdb_d;
            mem_q      <= mem_d;
            gap_seen_q <= gap_seen_d;
            sr_busy_q  <= sr_busy_d;
            sr_tgl_q   <= sr_tgl_d;
            dn1_q      <= core_done_tgl;
            dn2_q      <= dn1_q;
            dn_seen_q  <= dn_seen_d;
            wr_tgl_q   <= wr_tgl_d;
            wr_addr_q  <= wr_addr_d;
            wr_data_q  <= wr_data_d;
        end
    end

    // ----------------------------------------------------------------
    // read data launch on the falling edge
    // ----------------------------------------------------------------
    always_comb
    begin
        out_d = lsb ? rdb_q[cnt_q[2:0]] : rdb_q[3'h7 - cnt_q[2:0]];
        drv_d = (state_q == ST_DATA) && is_read_q && !i_port_select_n;
    end

    always_ff @(negedge i_sclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            out_q <= 1'b0;
            drv_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            drv_q <= drv_d;
        end
    end

    assign o_sdio               = out_q;
    assign o_dedicated_out_line = out_q;
    assign o_sdio_oe_n          = ~(drv_q && !oe_en && !i_port_select_n);
    assign o_dedicated_out_oe_n = ~oe_en;

    // ----------------------------------------------------------------
    // core-side shadow and calibration
    // ----------------------------------------------------------------
    cfg_core_side #(
        .DEPTH      (DEPTH),
        .CAL_CYCLES (CAL_CYCLES)
    ) u_core (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_wr_tgl   (wr_tgl_q),
        .i_wr_addr  (wr_addr_q),
        .i_wr_data  (wr_data_q),
        .i_sr_tgl   (sr_tgl_q),
        .o_done_tgl (core_done_tgl),
        .i_rd_addr  (i_cfg_addr),
        .o_rd_data  (o_cfg_data),
        .o_cal_busy (o_cal_busy)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_FOUR_WIRE: assert property (@(posedge i_sclk) disable iff (i_reset)
        oe_en |-> (o_sdio_oe_n && !o_dedicated_out_oe_n))
        else $error("data pin driven in four-wire mode");

    AST_DRIVE_DIR: assert property (@(posedge i_sclk) disable iff (i_reset)
        !o_sdio_oe_n |-> (state_q == ST_DATA) && is_read_q)
        else $error("data pin driven outside read data phase");

    AST_RESTART: assert property (@(posedge i_sclk) disable iff (i_reset)
        restart |=> (state_q == ST_HEADER) && (cnt_q == 4'h1))
        else $error("header not restarted on first edge");

    AST_LSB_SHIFT: assert property (@(posedge i_sclk) disable iff (i_reset)
        (!i_port_select_n && (s_eff == ST_HEADER) && lsb) |=> hdr_q[15] == $past(i_sdio))
        else $error("lsb-first header shift wrong");

    AST_STEP_UP: assert property (@(posedge i_sclk) disable iff (i_reset)
        (step_ev && !lsb) |=> addr_q == $past(addr_q) + 13'h0001)
        else $error("address did not increment");

    AST_STEP_DN: assert property (@(posedge i_sclk) disable iff (i_reset)
        (step_ev && lsb) |=> addr_q == $past(addr_q) - 13'h0001)
        else $error("address did not decrement");

    AST_HDR_DECODE: assert property (@(posedge i_sclk) disable iff (i_reset)
        hdr_done |=> (state_q == ST_DATA) && (is_read_q == $past(hdr_next[15])) &&
                     (addr_q == $past(hdr_next[12:0])) && (cnt_q == 4'h0))
        else $error("header decode wrong");

    AST_ONE_BYTE: assert property (@(posedge i_sclk) disable iff (i_reset)
        (step_ev && (code_q == 2'h0)) |=> state_q == ST_DONE)
        else $error("single byte transfer did not end");

    AST_PAUSE_KEEP: assert property (@(posedge i_sclk) disable iff (i_reset)
        (!i_port_select_n && stall && (state_q == ST_DATA) && (cnt_q == 4'h0) &&
         (code_q != CNT_FOUR_PLUS)) |=> (state_q == ST_DATA) && (cnt_q == 4'h1))
        else $error("short transfer lost on pause");

    AST_PAUSE_END: assert property (@(posedge i_sclk) disable iff (i_reset)
        (!i_port_select_n && stall && (state_q == ST_DATA) &&
         (code_q == CNT_FOUR_PLUS) && (bytes_q != 2'h0)) |=> state_q == ST_HEADER)
        else $error("long transfer survived late pause");

    AST_SRST_SET: assert property (@(posedge i_sclk) disable iff (i_reset)
        (step_ev && !is_read_q && (addr_q == CFG_ADDR) && byte_next[CFG_SRST_BIT])
        |=> sr_busy_q && (mem_q[1] == REG_RESET) && (sr_tgl_q != $past(sr_tgl_q)))
        else $error("soft reset not applied");

    AST_BURST_END: assert property (@(posedge i_sclk) disable iff (i_reset)
        (step_ev && (code_q == CNT_FOUR_PLUS) && (addr_q == {5'h00, burst_end}))
        |=> state_q == ST_DONE)
        else $error("burst did not stop at end address");

    COV_READ_DONE: cover property (@(posedge i_sclk) disable iff (i_reset)
        (state_q == ST_DONE) && is_read_q);
    COV_BURST: cover property (@(posedge i_sclk) disable iff (i_reset)
        step_ev && (code_q == CNT_FOUR_PLUS) && (bytes_q == 2'h3));
    COV_SRST: cover property (@(posedge i_sclk) disable iff (i_reset)
        $rose(sr_busy_q));

endmodule

`default_nettype wire

// ---- tb/host_master.sv ----
// Purpose: serial master model for the configuration port
// Assumes: one slave selected; clock low before select falls
// Notes:   data line is pulled up whenever neither side drives it
`timescale 1ns/1ps
`default_nettype none
module host_master
(
    output logic      o_sclk,
    output logic      o_sel_n,
    output logic      o_mosi,
    output logic      o_drive,
    input  wire logic i_miso
);
    initial
    begin
        o_sclk  = 1'b0;
        o_sel_n = 1'b1;
        o_mosi  = 1'b1;
        o_drive = 1'b0;
    end
    // clock only runs inside a frame; 48 ns bits stay under any rate limit
    // pz is the number of bits sent before a select pause, zero for none
    task automatic frame(input bit lsb, input int pz, input logic [15:0] hdr,
        input int n, input logic [47:0] wd, output logic [47:0] rd);
        int t;
        rd      = '0;
        o_sel_n = 1'b0;
        #24;
        for (int k = 0; k < 16 + 8 * n; k++)
        begin
            t = k < 16 ? (lsb ? k : 15 - k) : (lsb ? k - 16 : 8 * n + 15 - k);
            o_drive = k < 16 || !hdr[15];
            o_mosi  = k < 16 ? hdr[t] : wd[t];
            #24 o_sclk = 1'b1;
            if (k >= 16)
                rd[t] = i_miso;
            #24 o_sclk = 1'b0;
            if (k + 1 == pz)
            begin
                o_sel_n = 1'b1;
                #48 o_sel_n = 1'b0;
                #24;
            end
        end
        o_drive = 1'b0;
        #24 o_sel_n = 1'b1;
        #48;
    endtask
endmodule
`default_nettype wire

// ---- tb/adc_serial_config_port_test.sv ----
// Purpose: self-checking bench for the serial configuration port
// Assumes: calibration shortened to 8 core cycles
// Notes:   host_master plays the serial master
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_port_test;
    import spi_cfg_pkg::*;
    logic        clock     = 1'b0;
    logic        reset     = 1'b0;
    logic        seen_busy = 1'b0;
    logic [12:0] cfg_addr  = 13'h0000;
    logic [7:0]  cfg_data;
    logic        sclk, sel_n, mosi, drive, sdio, sdio_oe_n, ded, ded_oe_n, busy;
    logic [47:0] rd;
    int          n_fail, check_count, cyc, n_drive, n_mark;
    wire logic   line_w = !sdio_oe_n ? sdio : (drive ? mosi : 1'b1);
    wire logic   miso_w = !ded_oe_n ? ded : line_w;
    always #5 clock = ~clock;
    // serial edges at which the device drives the shared data pin
    always @(posedge sclk)
        if (!sdio_oe_n)
            n_drive++;
    always @(posedge clock)
    begin
        seen_busy <= seen_busy | busy;
        cyc       <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict;
        end
    end
    host_master host_master_i (.o_sclk(sclk), .o_sel_n(sel_n), .o_mosi(mosi),
        .o_drive(drive), .i_miso(miso_w));
    adc_serial_config_port #(.CAL_CYCLES(8)) adc_serial_config_port_i (.i_clock(clock),
        .i_reset(reset), .i_sclk(sclk), .i_port_select_n(sel_n), .i_sdio(line_w),
        .o_sdio(sdio), .o_sdio_oe_n(sdio_oe_n), .o_dedicated_out_line(ded),
        .o_dedicated_out_oe_n(ded_oe_n), .i_cfg_addr(cfg_addr), .o_cfg_data(cfg_data),
        .o_cal_busy(busy));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input bit lsb, input int pz, input logic [1:0] c,
        input logic [12:0] a, input int n, input logic [47:0] d);
        host_master_i.frame(lsb, pz, {1'b0, c, a}, n, d, rd);
    endtask
    task automatic rdx(input bit lsb, input logic [1:0] c, input logic [12:0] a, input int n);
        host_master_i.frame(lsb, 1'b0, {1'b1, c, a}, n, 48'h0000, rd);
    endtask
    // core-side shadow read, one cycle of latency plus margin
    task automatic sh(input logic [12:0] a);
        @(posedge clock);
        cfg_addr <= a;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        reset <= 1'b1;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rdx(0, 2'h0, CFG_ADDR, 1);
        check(rd, CFG_RESET);
        sh(CFG_ADDR);
        check(cfg_data, CFG_RESET);
        check(busy, 1'b0);
        $display("reset values done");
        // one byte more than the count code allows; it must be dropped
        for (int c = 0; c < 3; c++)
        begin
            wr(0, 0, c[1:0], 13'h0020, c + 2, 48'ha5c3_3c96);
            rdx(0, c[1:0], 13'h0020, c + 1);
            check(rd, (48'ha5c3_3c96 >> 8) & ~(48'hffff_ffff_ffff << (8 * c + 8)));
        end
        sh(13'h0021);
        check(cfg_data, 8'hc3);
        sh(13'h0023);
        check(cfg_data, 8'h00);
        wr(0, 0, 2'h0, BURST_END_ADDR, 1, 48'h0033);
        wr(0, 0, 2'h3, 13'h0030, 5, 48'h0011_2233_4455);
        sh(13'h0033);
        check(cfg_data, 8'h44);
        sh(13'h0034);
        check(cfg_data, 8'h00);
        wr(0, 8, 2'h0, 13'h0010, 1, 48'h005a);
        sh(13'h0010);
        check(cfg_data, 8'h5a);
        wr(0, 24, 2'h1, 13'h0050, 2, 48'h6699);
        sh(13'h0051);
        check(cfg_data, 8'h99);
        // a late pause cuts the burst; the rest is a fresh one-byte write
        wr(0, 24, 2'h3, 13'h0030, 4, 48'h0000_7700_3400);
        sh(13'h0030);
        check(cfg_data, 8'h77);
        sh(13'h0031);
        check(cfg_data, 8'h22);
        $display("counts and bursts done");
        wr(0, 0, 2'h0, CFG_ADDR, 1, 48'h0099);
        check(ded_oe_n, 1'b0);
        n_mark = n_drive;
        rdx(0, 2'h0, 13'h0010, 1);
        check(rd, 48'h005a);
        check(n_drive - n_mark, 0);
        check(sdio_oe_n, 1'b1);
        wr(0, 0, 2'h0, CFG_ADDR, 1, 48'h0018);
        n_mark = n_drive;
        rdx(0, 2'h0, 13'h0010, 1);
        check(rd, 48'h005a);
        check(n_drive - n_mark, 8);
        check(sdio_oe_n, 1'b1);
        check(ded_oe_n, 1'b1);
        wr(0, 0, 2'h0, CFG_ADDR, 1, 48'h005a);
        wr(1, 0, 2'h1, 13'h0041, 2, 48'h3c96);
        sh(13'h0041);
        check(cfg_data, 8'h96);
        sh(13'h0040);
        check(cfg_data, 8'h3c);
        rdx(1, 2'h1, 13'h0041, 2);
        check(rd, 48'h3c96);
        $display("wire modes and bit order done");
        wr(1, 0, 2'h0, CFG_ADDR, 1, 48'h007e);
        repeat (30) @(posedge clock);
        check(seen_busy, 1'b1);
        check(busy, 1'b0);
        rdx(0, 2'h0, CFG_ADDR, 1);
        check(rd, CFG_RESET);
        sh(13'h0041);
        check(cfg_data, 8'h00);
        sh(BURST_END_ADDR);
        check(cfg_data, BURST_END_RESET);
        $display("soft reset done");
        give_verdict;
    end
endmodule
`default_nettype wire
